/* File: rtl/meter_out_pkg.sv */
// Constants, register map and carrier types for the analog meter output control block.
// Assumes a 100 MHz hclk and a single AHB-Lite master reaching the register file.
package meter_out_pkg;

  // Clock rate and time figures, with the cycle counts derived from them.
  localparam int unsigned CLK_HZ           = 100_000_000;
  localparam int unsigned TEST_IDLE_S      = 30;
  localparam int unsigned DEBOUNCE_MS      = 10;
  localparam logic [31:0] TEST_IDLE_CYCLES = 32'(64'(TEST_IDLE_S) * 64'(CLK_HZ));
  localparam logic [31:0] DEBOUNCE_CYCLES  = 32'((64'(DEBOUNCE_MS) * 64'(CLK_HZ) + 64'd999) / 64'd1000);

  // Register byte addresses.
  localparam logic [31:0] SELECT_ADDR   = 32'h0000_0000;
  localparam logic [31:0] PLUG_ADDR     = 32'h0000_0004;
  localparam logic [31:0] VRATED_ADDR   = 32'h0000_0008;
  localparam logic [31:0] STATUS_ADDR   = 32'h0000_000C;
  localparam logic [31:0] FS_CUR_ADDR   = 32'h0000_0010;
  localparam logic [31:0] FS_VOLT_ADDR  = 32'h0000_0014;
  localparam logic [31:0] FS_PWR_ADDR   = 32'h0000_0018;
  localparam logic [31:0] FS_PWRT_ADDR  = 32'h0000_001C;
  localparam logic [31:0] MEAS_BASE     = 32'h0000_0040;
  localparam int unsigned MEAS_WORDS    = 20;

  // Reset values of the writable registers.
  localparam logic [3:0]  SELECT_RST = 4'h0;
  localparam logic [15:0] PLUG_RST   = 16'h0640;
  localparam logic [15:0] VRATED_RST = 16'h0190;

  // Selector positions: the left half spans positions 0 to 4.
  localparam logic [3:0] RIGHT_HALF_POS = 4'h5;
  localparam logic [3:0] LAST_POS       = 4'h9;

  // Status register field positions.
  localparam int unsigned ST_TEST = 0;
  localparam int unsigned ST_CHAN = 1;
  localparam int unsigned ST_ALL  = 3;
  localparam int unsigned ST_LED  = 4;
  localparam int unsigned ST_MOD  = 8;

  // Output level code: zero is 0 V / 4 mA, full is 10 V / 20 mA.
  localparam logic [11:0] LEVEL_MIN = 12'h000;
  localparam logic [11:0] LEVEL_MID = 12'h800;
  localparam logic [11:0] LEVEL_MAX = 12'hFFF;

  // Scaling of the fixed-range quantities (frequency in 0.01 Hz, power factor as
  // offset 0..600 in thousandths from 0.7 capacitive, unbalance in percent).
  localparam logic [31:0] FREQ_LO    = 32'h0000_1194;
  localparam logic [31:0] FREQ_SPAN  = 32'h0000_07D0;
  localparam logic [31:0] PF_SPAN    = 32'h0000_0258;
  localparam logic [31:0] PF_LED_LO  = 32'h0000_0064;
  localparam logic [31:0] PF_LED_HI  = 32'h0000_01F4;
  localparam logic [31:0] UNB_SPAN   = 32'h0000_0032;

  // Power range table: band upper bounds and their full-scale values.
  localparam int unsigned PWR_BANDS = 12;
  localparam logic [33:0] PWR_BOUND [PWR_BANDS] = '{
    34'd50_000, 34'd100_000, 34'd200_000, 34'd300_000, 34'd400_000, 34'd500_000,
    34'd1_000_000, 34'd2_000_000, 34'd3_000_000, 34'd5_000_000, 34'd10_000_000,
    34'd20_000_000};
  localparam logic [31:0] PWR_FS_TOP = 32'd30_000_000;

  // Operating modes picked by the selector, the per-channel quantity kinds, and the sequencer states.
  typedef enum logic [2:0] {mode_cur, mode_volt, mode_pwr, mode_freq, mode_pf} mode_t;
  typedef enum logic [2:0] {k_cur, k_volt, k_pwr, k_pwrt, k_freq, k_pf, k_unb} kind_t;
  typedef enum logic [1:0] {st_normal, st_armed, st_chan, st_all} test_state_t;

  // One channel: voltage-loop and current-loop level codes.
  typedef struct packed {
    logic [11:0] volt;
    logic [11:0] curr;
  } chan_out_t;

endpackage

/* File: rtl/meter_out_ctrl.sv */
// Analog meter output control: selector decode, scaling, threshold LEDs and test sequencer.
// Assumes measured values are written into the measurement words by the module bus agent
// over AHB-Lite, and that the test button is synchronous to hclk but may bounce.
// Operation
// RULE1: Four channels, each driving identical voltage and current-loop level codes.
// RULE2: Left-half selector positions make module one; right-half positions module two.
// RULE3: Integrator attaches at most two modules; the second uses a right-half position.
// RULE4: Current mode: channels carry three phase currents and the neutral current.
// RULE5: Current full scale is plug times 1.2, rounded up to a multiple of 100.
// RULE6: Voltage mode: channels carry L1-L2, L2-L3, L3-L1 and L1-neutral voltages.
// RULE7: Voltage full scale is rated voltage times 1.1, rounded up to 50.
// RULE8: Power mode: three phase active powers, then total apparent power.
// RULE9: Power base is plug times rated voltage; tripled for total powers.
// RULE10: Power full scale comes from the fixed range table, topping at 30M.
// RULE11: Frequency mode: frequency, mean line voltage, total power, mean power factor.
// RULE12: Frequency maps 45 Hz to lowest and 65 Hz to highest level.
// RULE13: Power-factor mode: three phase power factors, then current unbalance percent.
// RULE14: Power factor spans 0.7 capacitive to 0.7 inductive; unbalance spans 0 to 50%.
// RULE15: Channel LED lights above 20% scale, power factor above 0.8, frequency above 45 Hz.
// RULE16: A press enters test mode, lights device LED, withholds live values.
// RULE17: Next press selects channel one with full-scale or 55 Hz test level.
// RULE18: Each further press moves test level and LED to the next channel.
// RULE19: Press at channel four lights all LEDs, no level; next press gives channel one.
// RULE20: Thirty seconds without a press leaves test mode and restores live values.
// RULE21: The button is debounced into one press; each press restarts the idle timer.
`timescale 1ns/1ns
module meter_out_ctrl
  import meter_out_pkg::*;
#(
  parameter logic [31:0] IDLE_CYCLES     = TEST_IDLE_CYCLES,
  parameter logic [31:0] DEBOUNCE_LENGTH = DEBOUNCE_CYCLES
) (
  // Clock and reset.
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // AHB-Lite slave.
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // Front panel.
  input  wire logic              test_button,
  output logic                   device_led,
  output logic      [3:0]        chan_led,
  output logic                   module_id,
  // Channel level codes, index 0 is channel one.
  output chan_out_t [3:0]        chan_out
);

  logic [3:0]  sel_pos;
  logic [15:0] plug;
  logic [15:0] vrated;
  logic [31:0] meas [MEAS_WORDS];
  logic        a_phase;
  logic [31:0] a_addr;
  logic        a_write;
  logic [31:0] next_rdata;
  logic        meas_hit;
  logic [4:0]  meas_idx;
  mode_t       mode;
  logic [31:0] fs_cur;
  logic [31:0] fs_volt;
  logic [31:0] fs_pwr;
  logic [31:0] fs_pwrt;
  logic [33:0] pwr_base;
  logic [11:0] live_code [4];
  logic [3:0]  live_led;
  test_state_t state;
  logic [1:0]  sel_chan;
  logic [31:0] idle_cnt;
  logic        btn_meta;
  logic        btn_sync;
  logic        btn_state;
  logic [31:0] bounce_cnt;
  logic        press;

  // Map the measured value onto the output span, clamped at both ends.
  function automatic logic [11:0] scale(logic [31:0] val, logic [31:0] lo, logic [31:0] span);
    logic [47:0] prod;
    prod = 48'((val - lo)) * 48'(LEVEL_MAX);
    if (val <= lo) begin
      scale = LEVEL_MIN;
    end else if (val - lo >= span) begin
      scale = LEVEL_MAX;
    end else begin
      scale = 12'(prod / 48'(span));
    end
  endfunction

  // Look a power base up in the range table.
  function automatic logic [31:0] pwr_range(logic [33:0] base);
    pwr_range = PWR_FS_TOP;
    for (int b = PWR_BANDS - 1; b >= 0; b--) begin
      if (base < PWR_BOUND[b]) begin
        pwr_range = 32'(PWR_BOUND[b]);
      end
    end
  endfunction

  // Bus address phase; one wait state gives registered read data.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_phase   <= 1'b0;
      a_addr    <= 32'h0000_0000;
      a_write   <= 1'b0;
      hreadyout <= 1'b1;
    end else if (hsel && hready && htrans[1]) begin
      a_phase   <= 1'b1;
      a_addr    <= haddr;
      a_write   <= hwrite;
      hreadyout <= 1'b0;
    end else if (a_phase) begin
      a_phase   <= 1'b0;
      hreadyout <= 1'b1;
    end
  end

  // Every transfer is answered OKAY, unmapped ones included.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  assign meas_hit = (a_addr >= MEAS_BASE) && (a_addr < MEAS_BASE + 32'(MEAS_WORDS * 4))
                    && (a_addr[1:0] == 2'b00);
  assign meas_idx = 5'((a_addr - MEAS_BASE) >> 2);

  // Read mux; unmapped addresses read zero.
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (a_addr)
      SELECT_ADDR:  next_rdata = {28'h000_0000, sel_pos};
      PLUG_ADDR:    next_rdata = {16'h0000, plug};
      VRATED_ADDR:  next_rdata = {16'h0000, vrated};
      STATUS_ADDR: begin
        next_rdata[ST_TEST]           = (state != st_normal);
        next_rdata[ST_CHAN +: 2]      = sel_chan;
        next_rdata[ST_ALL]            = (state == st_all);
        next_rdata[ST_LED +: 4]       = chan_led;
        next_rdata[ST_MOD]            = module_id;
      end
      FS_CUR_ADDR:  next_rdata = fs_cur;
      FS_VOLT_ADDR: next_rdata = fs_volt;
      FS_PWR_ADDR:  next_rdata = fs_pwr;
      FS_PWRT_ADDR: next_rdata = fs_pwrt;
      default: begin
        if (meas_hit) begin
          next_rdata = meas[meas_idx];
        end
      end
    endcase
  end

  // Data phase: read data is loaded and writes take effect in the wait cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (a_phase && !a_write) begin
      hrdata <= next_rdata;
    end
  end

  // Configuration registers steer the scaling.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_pos <= SELECT_RST;
      plug    <= PLUG_RST;
      vrated  <= VRATED_RST;
    end else if (a_phase && a_write) begin
      if (a_addr == SELECT_ADDR) sel_pos <= hwdata[3:0];
      if (a_addr == PLUG_ADDR) plug <= hwdata[15:0];
      if (a_addr == VRATED_ADDR) vrated <= hwdata[15:0];
    end
  end

  // Measurement words clear on reset, so live codes and LEDs never carry unknown values.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int w = 0; w < MEAS_WORDS; w++) begin
        meas[w] <= 32'h0000_0000;
      end
    end else if (a_phase && a_write && meas_hit) begin
      meas[meas_idx] <= hwdata;
    end
  end

  // Positions past the last one fold back to the current mode.
  always_comb begin
    if (sel_pos < RIGHT_HALF_POS) begin
      mode = mode_t'(sel_pos[2:0]);
    end else if (sel_pos <= LAST_POS) begin
      mode = mode_t'(3'(sel_pos - RIGHT_HALF_POS));
    end else begin
      mode = mode_cur;
    end
  end

  // Module identity follows the selector half.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      module_id <= 1'b0;
    end else begin
      module_id <= (sel_pos >= RIGHT_HALF_POS); // RULE2
    end
  end

  // Full-scale values; round up by adding one step less one before dividing.
  assign fs_cur   = 32'(((32'(plug) * 32'd12 + 32'd999) / 32'd1000) * 32'd100); // RULE5
  assign fs_volt  = 32'(((32'(vrated) * 32'd11 + 32'd499) / 32'd500) * 32'd50); // RULE7
  assign pwr_base = 34'(32'(plug) * 32'(vrated)); // RULE9
  assign fs_pwr   = pwr_range(pwr_base); // RULE10
  assign fs_pwrt  = pwr_range(34'(pwr_base * 34'd3)); // RULE9

  // Per channel: pick the quantity, scale it, compare its threshold and drive the outputs.
  for (genvar i = 0; i < 4; i++) begin : g_chan
    kind_t       kind;
    logic [31:0] val;
    logic [31:0] lo;
    logic [31:0] span;
    logic [11:0] test_code;

    // Measurement word index is mode times four plus the channel.
    assign val = meas[{mode[2:0], 2'(i)}]; // RULE4 RULE6 RULE8 RULE11 RULE13

    always_comb begin
      case (mode)
        mode_cur:  kind = k_cur;
        mode_volt: kind = k_volt;
        mode_pwr:  kind = (i == 3) ? k_pwrt : k_pwr;
        mode_freq: kind = (i == 0) ? k_freq : (i == 1) ? k_volt : (i == 2) ? k_pwrt : k_pf;
        mode_pf:   kind = (i == 3) ? k_unb : k_pf;
        default:   kind = k_cur;
      endcase
    end

    always_comb begin
      lo = 32'h0000_0000;
      case (kind)
        k_cur:   span = fs_cur;
        k_volt:  span = fs_volt;
        k_pwr:   span = fs_pwr;
        k_pwrt:  span = fs_pwrt;
        k_freq: begin
          lo   = FREQ_LO; // RULE12
          span = FREQ_SPAN;
        end
        k_pf:    span = PF_SPAN; // RULE14
        k_unb:   span = UNB_SPAN; // RULE14
        default: span = fs_cur;
      endcase
    end

    assign live_code[i] = scale(val, lo, span);
    // Frequency and power-factor quantities test at the 55 Hz level, which is mid-scale.
    assign test_code = (kind == k_freq || kind == k_pf || kind == k_unb) ? LEVEL_MID
                       : LEVEL_MAX; // RULE17

    always_comb begin
      if (kind == k_freq) begin
        live_led[i] = (val > FREQ_LO); // RULE15
      end else if (kind == k_pf) begin
        live_led[i] = (val > PF_LED_LO) && (val < PF_LED_HI); // RULE15
      end else begin
        live_led[i] = (35'(val) * 35'd5 > 35'(span)); // RULE15
      end
    end

    // Both loop forms always carry the same code; test mode withholds live values.
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        chan_out[i] <= '0;
        chan_led[i] <= 1'b0;
      end else if (state == st_normal) begin
        chan_out[i] <= '{volt: live_code[i], curr: live_code[i]}; // RULE1 RULE16
        chan_led[i] <= live_led[i];
      end else if (state == st_chan && sel_chan == 2'(i)) begin
        chan_out[i] <= '{volt: test_code, curr: test_code}; // RULE17 RULE18
        chan_led[i] <= 1'b1;
      end else begin
        chan_out[i] <= '{volt: LEVEL_MIN, curr: LEVEL_MIN}; // RULE19
        chan_led[i] <= (state == st_all); // RULE19
      end
    end

    a_led_live: assert property (@(posedge hclk) disable iff (!hresetn) // RULE15
      (state == st_normal) ##1 (state == st_normal) |-> chan_led[i] == $past(live_led[i]))
      else $error("channel LED does not follow its threshold");

    a_dual_form: assert property (@(posedge hclk) disable iff (!hresetn) // RULE1
      (state == st_normal) |=> chan_out[i].volt == chan_out[i].curr
                               && chan_out[i].volt == $past(live_code[i]))
      else $error("channel forms differ or miss the live value");
  end

  // The first flop of the button synchroniser feeds only the second.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      btn_meta <= 1'b0;
      btn_sync <= 1'b0;
    end else begin
      btn_meta <= test_button;
      btn_sync <= btn_meta;
    end
  end

  // A level change must hold for the debounce time before it counts.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      btn_state  <= 1'b0;
      bounce_cnt <= 32'h0000_0000;
      press      <= 1'b0;
    end else begin
      press <= 1'b0;
      if (btn_sync == btn_state) begin
        bounce_cnt <= 32'h0000_0000;
      end else if (bounce_cnt >= DEBOUNCE_LENGTH - 32'd1) begin
        btn_state  <= btn_sync; // RULE21
        bounce_cnt <= 32'h0000_0000;
        press      <= btn_sync;
      end else begin
        bounce_cnt <= bounce_cnt + 32'd1;
      end
    end
  end

  // Test sequencer; a press outranks a timeout landing in the same cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state    <= st_normal;
      sel_chan <= 2'b00;
    end else if (press) begin
      case (state)
        st_normal: state <= st_armed; // RULE16
        st_armed, st_all: begin
          state    <= st_chan; // RULE17 RULE19
          sel_chan <= 2'b00;
        end
        st_chan: begin
          if (sel_chan == 2'b11) begin
            state <= st_all; // RULE19
          end else begin
            sel_chan <= sel_chan + 2'b01; // RULE18
          end
        end
        default: state <= st_normal;
      endcase
    end else if (state != st_normal && idle_cnt >= IDLE_CYCLES - 32'd1) begin
      state    <= st_normal; // RULE20
      sel_chan <= 2'b00;
    end
  end

  // Idle timer restarts on every accepted press and rests outside test mode.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idle_cnt <= 32'h0000_0000;
    end else if (press || state == st_normal) begin
      idle_cnt <= 32'h0000_0000; // RULE21
    end else begin
      idle_cnt <= idle_cnt + 32'd1; // RULE20
    end
  end

  // Device LED shows test mode.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      device_led <= 1'b0;
    end else begin
      device_led <= (state != st_normal); // RULE16
    end
  end

  a_test_entry: assert property (@(posedge hclk) disable iff (!hresetn) // RULE16
    (state == st_normal && press) |=> (state == st_armed) ##1 device_led)
    else $error("press did not enter test mode");

  a_first_chan: assert property (@(posedge hclk) disable iff (!hresetn) // RULE17
    (state == st_armed && press) |=> (sel_chan == 2'b00) ##1 chan_led == 4'b0001)
    else $error("channel one not selected");

  a_chan_step: assert property (@(posedge hclk) disable iff (!hresetn) // RULE18
    (state == st_chan && press && sel_chan != 2'b11) |=> sel_chan == $past(sel_chan) + 2'b01)
    else $error("test channel did not advance");

  a_all_leds: assert property (@(posedge hclk) disable iff (!hresetn) // RULE19
    (state == st_chan && press && sel_chan == 2'b11) |=> ##1 chan_led == 4'b1111
      && chan_out[3].volt == LEVEL_MIN)
    else $error("all-LED step wrong");

  a_idle_exit: assert property (@(posedge hclk) disable iff (!hresetn) // RULE20
    (state != st_normal && !press && idle_cnt == IDLE_CYCLES - 32'd1) |=> state == st_normal)
    else $error("test mode did not time out");

  a_module_half: assert property (@(posedge hclk) disable iff (!hresetn) // RULE2
    (a_phase && a_write && a_addr == SELECT_ADDR) |-> ##2
      module_id == ($past(hwdata[3:0], 2) >= RIGHT_HALF_POS))
    else $error("module identity does not follow the selector half");

  a_fs_current: assert property (@(posedge hclk) disable iff (!hresetn) // RULE5
    (36'(fs_cur) * 36'd10 >= 36'(plug) * 36'd12)
      && (36'(fs_cur) * 36'd10 < 36'(plug) * 36'd12 + 36'd1000) && (fs_cur % 32'd100 == 0))
    else $error("current full scale off");

  a_fs_voltage: assert property (@(posedge hclk) disable iff (!hresetn) // RULE7
    (36'(fs_volt) * 36'd10 >= 36'(vrated) * 36'd11)
      && (36'(fs_volt) * 36'd10 < 36'(vrated) * 36'd11 + 36'd500) && (fs_volt % 32'd50 == 0))
    else $error("voltage full scale off");

  a_pwr_table: assert property (@(posedge hclk) disable iff (!hresetn) // RULE10
    (34'(fs_pwr) > pwr_base || fs_pwr == PWR_FS_TOP) && (fs_pwrt >= fs_pwr))
    else $error("power full scale below its base");

endmodule

/* File: bench/test_button_model.sv */
// Partner model of the front-panel test button: a contact that chatters on each edge.
// Assumes the bench calls press() from its main sequence, clocked by hclk.
`timescale 1ns/1ns
module test_button_model (
  // Clock and contact.
  input  wire logic hclk,
  output logic      test_button
);
  initial test_button = 1'b0;

  // Chatter shorter than the debounce window, then a long stable level.
  // A real contact never lands cleanly, so a clean edge would prove little.
  task automatic settle(input logic lvl);
    repeat (3) begin
      @(posedge hclk) test_button <= lvl;
      @(posedge hclk) test_button <= ~lvl;
    end
    @(posedge hclk) test_button <= lvl;
    repeat (20) @(posedge hclk);
  endtask

  // One full press and release.
  task automatic press();
    settle(1'b1);
    settle(1'b0);
  endtask
endmodule

/* File: bench/analog_meter_output_control_tb.sv */
// Self-checking bench for the meter output control block.
// Assumes this bench is the only AHB-Lite master and the button model is the partner.
`timescale 1ns/1ns
module analog_meter_output_control_tb
  import meter_out_pkg::*;
  ;
  logic            hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic            test_button, device_led, module_id;
  logic [1:0]      htrans;
  logic [2:0]      hsize;
  logic [31:0]     haddr, hwdata, hrdata, r;
  logic [3:0]      chan_led;
  chan_out_t [3:0] chan_out;
  int              failures, checks, cycles;
  // Full-scale span of each measurement word with the reset plug and rated voltage.
  int              span [20] = '{2000, 2000, 2000, 2000, 450, 450, 450, 450,
                                 1000000, 1000000, 1000000, 2000000,
                                 2000, 450, 2000000, 600, 600, 600, 600, 50};

  // The single slave drives the bus ready.
  assign hready = hreadyout;

  meter_out_ctrl #(.IDLE_CYCLES(32'h0000_00C8), .DEBOUNCE_LENGTH(32'h0000_0004))
    meter_out_ctrl_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .test_button(test_button),
    .device_led(device_led), .chan_led(chan_led), .module_id(module_id), .chan_out(chan_out));

  test_button_model test_button_model_i (.hclk(hclk), .test_button(test_button));

  // Clock at 100 MHz.
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // Hang guard, sized well above the thousand or so cycles the tests need.
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      wrap_up();
    end
  end

  // Verdict and end of run.
  task automatic wrap_up();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One AHB-Lite single transfer; address held until taken, data until ready.
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask

  task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(what, exp, r);
    chk("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
  endtask

  // Offset and stimulus value of each measurement word.
  function automatic int lo(input int i);
    return (i == 12) ? 4500 : 0;
  endfunction
  function automatic int val(input int i);
    return lo(i) + span[i] * (i % 4 + 1) / 5;
  endfunction

  task automatic chk_out(input string what, input logic [11:0] e [4], input logic [3:0] led);
    for (int c = 0; c < 4; c++) begin
      chk(what, {20'h0_0000, e[c]}, {20'h0_0000, chan_out[c].volt});
      chk(what, {20'h0_0000, e[c]}, {20'h0_0000, chan_out[c].curr});
    end
    chk(what, {28'h000_0000, led}, {28'h000_0000, chan_led});
  endtask

  // Live codes and LEDs for a selector position, worked out from spans and thresholds.
  task automatic chk_live(input int pos);
    logic [11:0] e [4];
    logic [3:0]  led;
    int          i;
    for (int c = 0; c < 4; c++) begin
      i = (pos % 5) * 4 + c;
      e[c] = 12'(longint'(val(i) - lo(i)) * 4095 / span[i]);
      if (i == 12) led[c] = val(i) > 4500;
      else if (i > 14 && i < 19) led[c] = val(i) > 100 && val(i) < 500;
      else led[c] = val(i) * 5 > span[i];
    end
    chk_out("live outputs", e, led);
  endtask

  // Test-mode outputs in the frequency position; sel below zero means no channel driven.
  task automatic chk_test(input int sel, input logic [3:0] led);
    logic [11:0] e [4];
    for (int c = 0; c < 4; c++) begin
      e[c] = (c != sel) ? LEVEL_MIN : (c == 0 || c == 3) ? LEVEL_MID : LEVEL_MAX;
    end
    chk_out("test outputs", e, led);
    chk("device led", 32'h0000_0001, {31'h0000_0000, device_led});
  endtask

  // Main sequence.
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0000_0000;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk("select", SELECT_ADDR, 32'h0000_0000);
    rd_chk("plug", PLUG_ADDR, 32'h0000_0640);
    rd_chk("vrated", VRATED_ADDR, 32'h0000_0190);
    rd_chk("unmapped", 32'h0000_0100, 32'h0000_0000);
    bus(1'b1, FS_CUR_ADDR, 32'h0000_0000);
    rd_chk("fs current", FS_CUR_ADDR, 32'h0000_07D0);
    rd_chk("fs voltage", FS_VOLT_ADDR, 32'h0000_01C2);
    rd_chk("fs power", FS_PWR_ADDR, 32'h000F_4240);
    rd_chk("fs total", FS_PWRT_ADDR, 32'h001E_8480);
    // Band edges: 1667 A rounds up to 2100, its tripled base passes 2M.
    bus(1'b1, PLUG_ADDR, 32'h0000_0683);
    bus(1'b1, VRATED_ADDR, 32'h0000_019A);
    rd_chk("fs current", FS_CUR_ADDR, 32'h0000_0834);
    rd_chk("fs voltage", FS_VOLT_ADDR, 32'h0000_01F4);
    rd_chk("fs total", FS_PWRT_ADDR, 32'h002D_C6C0);
    bus(1'b1, PLUG_ADDR, 32'h0000_FFFF);
    rd_chk("fs top", FS_PWRT_ADDR, 32'h01C9_C380);
    bus(1'b1, PLUG_ADDR, 32'h0000_0640);
    bus(1'b1, VRATED_ADDR, 32'h0000_0190);
    $display("test registers done");
    for (int i = 0; i < 20; i++) bus(1'b1, MEAS_BASE + 32'(4 * i), 32'(val(i)));
    for (int pos = 0; pos < 10; pos++) begin
      bus(1'b1, SELECT_ADDR, 32'(pos));
      repeat (3) @(posedge hclk);
      chk_live(pos);
      chk("module id", (pos > 4) ? 32'h0000_0001 : 32'h0000_0000, {31'h0000_0000, module_id});
    end
    $display("test channel mapping done");
    bus(1'b1, SELECT_ADDR, 32'h0000_0003);
    test_button_model_i.press();
    chk_test(-1, 4'h0);
    for (int s = 0; s < 4; s++) begin
      test_button_model_i.press();
      chk_test(s, 4'(1 << s));
    end
    test_button_model_i.press();
    chk_test(-1, 4'hF);
    rd_chk("status", STATUS_ADDR, 32'h0000_00FF);
    test_button_model_i.press();
    chk_test(0, 4'h1);
    $display("test sequencer done");
    // A press late in the idle window must restart it.
    repeat (130) @(posedge hclk);
    test_button_model_i.press();
    repeat (110) @(posedge hclk);
    chk_test(1, 4'h2);
    repeat (100) @(posedge hclk);
    chk("device led", 32'h0000_0000, {31'h0000_0000, device_led});
    chk_live(3);
    $display("test idle timeout done");
    wrap_up();
  end
endmodule
